// ---- radio_rx_host_port.v ----
// Behaviour
// - Serial input bits are taken on rising serial clock edges.
// - Host frames each access with low chip select; port answers only while selected.
// - Chip select held over several bytes gives a burst read or write.
// - Read accesses shift register contents out on the serial output.
// - Interrupt output goes low while any enabled interrupt event is pending.
// - Shutdown high loads power-on defaults into all registers and empties the queue; they hold them after release.
// - Three general purpose pins take their function from 0x0B to 0x0D.
// - Carrier value is sixteen bits: high byte 0x76, low byte 0x77.
// - Hop step is an eight-bit read/write register at 0x7A, reset 0x00.
// - Receive queue control at 0x7E holds a six-bit almost-full threshold.
// - Queue data port at 0x7F moves queue bytes.
`include "radio_rx_host_consts.vh"

module radio_rx_host_port #(
	parameter DEPTH = 64,
	parameter AW = 6,
	parameter NFUNC = 32
) (
	// Clock and reset.
	input wire clk_i,
	input wire rst_n_i,
	// Four-line serial bus.
	input wire sclk_i,
	input wire chip_select_n_i,
	input wire serial_in_i,
	output reg serial_out_o,
	output reg serial_out_oe_n_o,
	// Shutdown and interrupt pins.
	input wire shutdown_in_i,
	output reg irq_out_n_o,
	// Interrupt events from the radio core, one-cycle pulses.
	input wire [15:0] irq_event_i,
	// General purpose pins and their candidate sources.
	input wire [NFUNC-1:0] gpio_src_i,
	output reg [2:0] gpio_o,
	// Received bytes from the demodulator.
	input wire [7:0] rx_data_i,
	input wire rx_valid_i,
	output reg rx_ready_o,
	output reg almost_full_o,
	// Frequency settings toward the synthesiser.
	output reg side_band_o,
	output reg high_band_o,
	output reg [4:0] band_field_o,
	output reg [15:0] carrier_value_o,
	output reg [7:0] hop_channel_o,
	output reg [7:0] hop_step_o
);

// ============================================================
// Pin synchronisation and edge detection.
wire [3:0] pins_s;
wire off_s = pins_s[3];
wire sclk_s = pins_s[2];
wire cs_n_s = pins_s[1];
wire sdi_s = pins_s[0];
reg sclk_d_r;
sync2 #(.WIDTH(4), .RST_VAL(4'b0010)) u_sync (
	.clk_i(clk_i),
	.rst_n_i(rst_n_i),
	.d_i({shutdown_in_i, sclk_i, chip_select_n_i, serial_in_i}),
	.q_o(pins_s)
);
// Edges count only inside a frame, so stray clocks while deselected do nothing.
wire sclk_rise = sclk_s & ~sclk_d_r & ~cs_n_s & ~off_s;
wire sclk_fall = ~sclk_s & sclk_d_r & ~cs_n_s & ~off_s;
// ============================================================
// Serial engine state.
reg [6:0] shift_r;
reg [2:0] bit_cnt_r;
reg first_r;
reg write_r;
reg [6:0] addr_r;
reg [7:0] tx_r;
wire [7:0] byte_in = {shift_r, sdi_s};
wire byte_done = sclk_rise & (bit_cnt_r == 3'd7);
wire [6:0] acc_addr = first_r ? byte_in[6:0] : addr_r;
wire rd_fire = byte_done & (first_r ? ~byte_in[`SPI_WRITE_BIT] : ~write_r);
wire wr_fire = byte_done & ~first_r & write_r;
// The data port holds its address in a burst so the host can drain the queue in one frame.
wire [6:0] addr_next = (acc_addr == `ADDR_QUEUE_DATA_PORT) ? acc_addr : acc_addr + 7'd1;

// ============================================================
// Register storage.
reg [7:0] band_r, freq_hi_r, freq_lo_r, hop_ch_r, hop_step_r, rxq_ctrl_r;
reg [15:0] irq_status_r;
reg [15:0] irq_enable_r;
reg [7:0] gpio_cfg_r [0:2];
reg [7:0] mem_r [0:DEPTH-1];
reg [AW-1:0] wr_ptr_r, rd_ptr_r;
reg [AW:0] count_r;
reg [7:0] rd_data;
integer i;
integer k;
wire pop = rd_fire & (acc_addr == `ADDR_QUEUE_DATA_PORT) & (count_r != {(AW+1){1'b0}});
wire push = rx_valid_i & rx_ready_o;
wire [AW:0] count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
wire af_nxt = count_nxt >= {1'b0, rxq_ctrl_r[`RXQ_THR_MSB:0]};
wire [15:0] irq_set = irq_event_i | ({15'h0000, af_nxt & ~almost_full_o} << `IRQ_ALMOST_FULL_BIT);
wire [15:0] irq_clr = {{8{rd_fire & (acc_addr == `ADDR_IRQ_STATUS_1)}}, {8{rd_fire & (acc_addr == `ADDR_IRQ_STATUS_2)}}};
// Read mux; unmapped addresses answer zero.
always @*
begin
	case (acc_addr)
		`ADDR_IRQ_STATUS_1: rd_data = irq_status_r[15:8];
		`ADDR_IRQ_STATUS_2: rd_data = irq_status_r[7:0];
		`ADDR_IRQ_ENABLE_1: rd_data = irq_enable_r[15:8];
		`ADDR_IRQ_ENABLE_2: rd_data = irq_enable_r[7:0];
		`ADDR_GPIO_CFG_0: rd_data = gpio_cfg_r[0];
		`ADDR_GPIO_CFG_1: rd_data = gpio_cfg_r[1];
		`ADDR_GPIO_CFG_2: rd_data = gpio_cfg_r[2];
		`ADDR_BAND_SELECT: rd_data = {1'b0, band_r[6:0]};
		`ADDR_CARRIER_FREQ_HIGH: rd_data = freq_hi_r;
		`ADDR_CARRIER_FREQ_LOW: rd_data = freq_lo_r;
		`ADDR_HOP_CHANNEL: rd_data = hop_ch_r;
		`ADDR_HOP_STEP: rd_data = hop_step_r;
		`ADDR_RX_QUEUE_CONTROL: rd_data = {2'b00, rxq_ctrl_r[5:0]};
		`ADDR_QUEUE_DATA_PORT: rd_data = (count_r != {(AW+1){1'b0}}) ? mem_r[rd_ptr_r] : 8'h00;
		default: rd_data = 8'h00;
	endcase
end
// ============================================================
// Serial engine: shifts in on rising edges, updates the output on falling edges.
always @(posedge clk_i or negedge rst_n_i)
begin
	if (!rst_n_i)
	begin
		sclk_d_r <= 1'b0;
		shift_r <= 7'h00;
		bit_cnt_r <= 3'd0;
		first_r <= 1'b1;
		write_r <= 1'b0;
		addr_r <= 7'h00;
		tx_r <= 8'h00;
		serial_out_o <= 1'b0;
		serial_out_oe_n_o <= 1'b1;
	end
	else if (off_s || cs_n_s)
	begin
		// Deselect ends the frame at once; a half byte is dropped.
		sclk_d_r <= sclk_s;
		bit_cnt_r <= 3'd0;
		first_r <= 1'b1;
		serial_out_oe_n_o <= 1'b1;
		if (off_s)
		begin
			shift_r <= 7'h00;
			write_r <= 1'b0;
			addr_r <= 7'h00;
			tx_r <= 8'h00;
			serial_out_o <= 1'b0;
		end
	end
	else
	begin
		sclk_d_r <= sclk_s;
		serial_out_oe_n_o <= 1'b0;
		if (sclk_rise)
		begin
			shift_r <= byte_in[6:0];
			bit_cnt_r <= bit_cnt_r + 3'd1;
		end
		if (byte_done)
		begin
			first_r <= 1'b0;
			addr_r <= (first_r && byte_in[`SPI_WRITE_BIT]) ? byte_in[6:0] : addr_next;
			if (first_r)
				write_r <= byte_in[`SPI_WRITE_BIT];
			if (rd_fire)
				tx_r <= rd_data;
		end
		if (sclk_fall)
			serial_out_o <= tx_r[3'd7 - bit_cnt_r];
	end
end

// ============================================================
// Configuration registers; shutdown returns every one to its default.
always @(posedge clk_i or negedge rst_n_i)
begin
	if (!rst_n_i)
	begin
		band_r <= `RST_BAND_SELECT;
		freq_hi_r <= `RST_CARRIER_FREQ_HIGH;
		freq_lo_r <= `RST_CARRIER_FREQ_LOW;
		hop_ch_r <= `RST_HOP_CHANNEL;
		hop_step_r <= `RST_HOP_STEP;
		rxq_ctrl_r <= `RST_RX_QUEUE_CONTROL;
		irq_enable_r <= {`RST_IRQ_ENABLE, `RST_IRQ_ENABLE};
		for (i = 0; i < 3; i = i + 1)
			gpio_cfg_r[i] <= `RST_GPIO_CFG;
	end
	else if (off_s)
	begin
		band_r <= `RST_BAND_SELECT;
		freq_hi_r <= `RST_CARRIER_FREQ_HIGH;
		freq_lo_r <= `RST_CARRIER_FREQ_LOW;
		hop_ch_r <= `RST_HOP_CHANNEL;
		hop_step_r <= `RST_HOP_STEP;
		rxq_ctrl_r <= `RST_RX_QUEUE_CONTROL;
		irq_enable_r <= {`RST_IRQ_ENABLE, `RST_IRQ_ENABLE};
		for (i = 0; i < 3; i = i + 1)
			gpio_cfg_r[i] <= `RST_GPIO_CFG;
	end
	else if (wr_fire)
	begin
		// Writes to the data port and to reserved addresses fall through unused.
		case (addr_r)
			`ADDR_IRQ_ENABLE_1: irq_enable_r[15:8] <= byte_in;
			`ADDR_IRQ_ENABLE_2: irq_enable_r[7:0] <= byte_in;
			`ADDR_GPIO_CFG_0: gpio_cfg_r[0] <= byte_in;
			`ADDR_GPIO_CFG_1: gpio_cfg_r[1] <= byte_in;
			`ADDR_GPIO_CFG_2: gpio_cfg_r[2] <= byte_in;
			`ADDR_BAND_SELECT: band_r <= {1'b0, byte_in[6:0]};
			`ADDR_CARRIER_FREQ_HIGH: freq_hi_r <= byte_in;
			`ADDR_CARRIER_FREQ_LOW: freq_lo_r <= byte_in;
			`ADDR_HOP_CHANNEL: hop_ch_r <= byte_in;
			`ADDR_HOP_STEP: hop_step_r <= byte_in;
			`ADDR_RX_QUEUE_CONTROL: rxq_ctrl_r <= {2'b00, byte_in[5:0]};
			default: band_r <= band_r;
		endcase
	end
end

// ============================================================
// Receive queue, status flags and pin outputs.
always @(posedge clk_i or negedge rst_n_i)
begin
	if (!rst_n_i)
	begin
		wr_ptr_r <= {AW{1'b0}};
		rd_ptr_r <= {AW{1'b0}};
		count_r <= {(AW+1){1'b0}};
		rx_ready_o <= 1'b0;
		almost_full_o <= 1'b0;
		irq_status_r <= 16'h0000;
		irq_out_n_o <= 1'b1;
		gpio_o <= 3'b000;
		side_band_o <= 1'b0;
		high_band_o <= 1'b0;
		band_field_o <= 5'h00;
		carrier_value_o <= 16'h0000;
		hop_channel_o <= 8'h00;
		hop_step_o <= 8'h00;
	end
	else if (off_s)
	begin
		// Queue contents are lost in shutdown, like every register.
		wr_ptr_r <= {AW{1'b0}};
		rd_ptr_r <= {AW{1'b0}};
		count_r <= {(AW+1){1'b0}};
		rx_ready_o <= 1'b0;
		almost_full_o <= 1'b0;
		irq_status_r <= 16'h0000;
		irq_out_n_o <= 1'b1;
		gpio_o <= 3'b000;
		side_band_o <= band_r[`BAND_SIDE_BIT];
		high_band_o <= band_r[`BAND_HIGH_BIT];
		band_field_o <= band_r[`BAND_FIELD_MSB:0];
		carrier_value_o <= {freq_hi_r, freq_lo_r};
		hop_channel_o <= hop_ch_r;
		hop_step_o <= hop_step_r;
	end
	else
	begin
		if (push)
		begin
			mem_r[wr_ptr_r] <= rx_data_i;
			wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
		end
		if (pop)
			rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
		count_r <= count_nxt;
		rx_ready_o <= count_nxt < DEPTH[AW:0];
		almost_full_o <= af_nxt;
		// A new event beats the clear-on-read in the same cycle.
		irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
		irq_out_n_o <= ~|(irq_status_r & irq_enable_r);
		for (k = 0; k < 3; k = k + 1)
			gpio_o[k] <= gpio_src_i[gpio_cfg_r[k][`GPIO_FUNC_MSB:0]];
		// Frequency outputs follow their registers; the reset branch stays alone at the top for synthesis.
		side_band_o <= band_r[`BAND_SIDE_BIT];
		high_band_o <= band_r[`BAND_HIGH_BIT];
		band_field_o <= band_r[`BAND_FIELD_MSB:0];
		carrier_value_o <= {freq_hi_r, freq_lo_r};
		hop_channel_o <= hop_ch_r;
		hop_step_o <= hop_step_r;
	end
end

endmodule // radio_rx_host_port

// ---- radio_rx_host_consts.vh ----
`ifndef RADIO_RX_HOST_CONSTS_VH
`define RADIO_RX_HOST_CONSTS_VH

// ============================================================
// Register addresses, seven bits as sent after the direction bit.
`define ADDR_IRQ_STATUS_1 7'h03
`define ADDR_IRQ_STATUS_2 7'h04
`define ADDR_IRQ_ENABLE_1 7'h05
`define ADDR_IRQ_ENABLE_2 7'h06
`define ADDR_GPIO_CFG_0 7'h0b
`define ADDR_GPIO_CFG_1 7'h0c
`define ADDR_GPIO_CFG_2 7'h0d
`define ADDR_BAND_SELECT 7'h75
`define ADDR_CARRIER_FREQ_HIGH 7'h76
`define ADDR_CARRIER_FREQ_LOW 7'h77
`define ADDR_HOP_CHANNEL 7'h79
`define ADDR_HOP_STEP 7'h7a
`define ADDR_RX_QUEUE_CONTROL 7'h7e
`define ADDR_QUEUE_DATA_PORT 7'h7f

// ============================================================
// Reset values.
`define RST_BAND_SELECT 8'h75
`define RST_CARRIER_FREQ_HIGH 8'hbb
`define RST_CARRIER_FREQ_LOW 8'h80
`define RST_HOP_CHANNEL 8'h00
`define RST_HOP_STEP 8'h00
`define RST_RX_QUEUE_CONTROL 8'h37
`define RST_IRQ_ENABLE 8'h00
`define RST_GPIO_CFG 8'h00

// ============================================================
// Field positions.
`define BAND_SIDE_BIT 6
`define BAND_HIGH_BIT 5
`define BAND_FIELD_MSB 4
`define RXQ_THR_MSB 5
`define GPIO_FUNC_MSB 4
`define SPI_WRITE_BIT 7
`define IRQ_ALMOST_FULL_BIT 12

`endif

// ---- sync2.v ----
// ============================================================
// Two-stage synchroniser for levels from outside the clock domain.
module sync2 #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
	// Clock and reset.
	input wire clk_i,
	input wire rst_n_i,
	// Asynchronous levels in, synchronised levels out.
	input wire [WIDTH-1:0] d_i,
	output reg [WIDTH-1:0] q_o
);

reg [WIDTH-1:0] meta_r;

// The first stage feeds only the second stage, so no logic sees a metastable value.
always @(posedge clk_i or negedge rst_n_i)
begin
	if (!rst_n_i)
	begin
		meta_r <= RST_VAL;
		q_o <= RST_VAL;
	end
	else
	begin
		meta_r <= d_i;
		q_o <= meta_r;
	end
end

endmodule // sync2

// ---- radio_rx_host_monitor.sv ----
module radio_rx_host_monitor (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic sclk_i,
	input wire logic chip_select_n_i,
	input wire logic shutdown_in_i,
	input wire logic serial_out_o,
	input wire logic serial_out_oe_n_o,
	input wire logic irq_out_n_o,
	input wire logic almost_full_o,
	input wire logic side_band_o,
	input wire logic high_band_o,
	input wire logic [4:0] band_field_o,
	input wire logic [15:0] carrier_value_o,
	input wire logic [7:0] hop_channel_o,
	input wire logic [7:0] hop_step_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// ============================================================
	// Holds are long enough to cross the synchroniser and the output register.
	sequence shdn_held;
		shutdown_in_i [*6];
	endsequence
	sequence desel_held;
		chip_select_n_i [*5];
	endsequence
	sequence sclk_high;
		(sclk_i && !chip_select_n_i) [*6];
	endsequence
	chk_desel_quiet: assert property (desel_held |-> serial_out_oe_n_o) else $error("output driven while idle");
	chk_out_steady: assert property (sclk_high |-> $stable(serial_out_o)) else $error("output moved in high clock");
	chk_shdn_tristate: assert property (shdn_held |-> serial_out_oe_n_o) else $error("output driven in shutdown");
	chk_shdn_irq: assert property (shdn_held |-> irq_out_n_o) else $error("interrupt low in shutdown");
	chk_shdn_queue: assert property (shdn_held |-> !almost_full_o) else $error("queue not emptied");
	chk_shdn_carrier: assert property (shdn_held |-> carrier_value_o == 16'hbb80) else $error("carrier not default");
	chk_shdn_band: assert property (shdn_held |-> {side_band_o, high_band_o, band_field_o} == 7'h75) else $error("band bad");
	chk_shdn_hop: assert property (shdn_held |-> {hop_channel_o, hop_step_o} == 16'h0000) else $error("hop not default");
endmodule // radio_rx_host_monitor

bind radio_rx_host_port radio_rx_host_monitor u_radio_rx_host_monitor (
	.clk_i(clk_i),
	.rst_n_i(rst_n_i),
	.sclk_i(sclk_i),
	.chip_select_n_i(chip_select_n_i),
	.shutdown_in_i(shutdown_in_i),
	.serial_out_o(serial_out_o),
	.serial_out_oe_n_o(serial_out_oe_n_o),
	.irq_out_n_o(irq_out_n_o),
	.almost_full_o(almost_full_o),
	.side_band_o(side_band_o),
	.high_band_o(high_band_o),
	.band_field_o(band_field_o),
	.carrier_value_o(carrier_value_o),
	.hop_channel_o(hop_channel_o),
	.hop_step_o(hop_step_o)
);

// ---- spi_host_model.sv ----
module spi_host_model (
	// Clock and read-back line.
	input wire logic clk_i,
	input wire logic serial_out_i,
	// Bus lines driven by the host.
	output logic sclk_o,
	output logic chip_select_n_o,
	output logic serial_in_o
);
	timeunit 1ns;
	timeprecision 10ps;
	// ============================================================
	// Serial clock stands low between frames.
	initial
	begin
		sclk_o = 1'b0;
		chip_select_n_o = 1'b1;
		serial_in_o = 1'b0;
	end
	// One byte MSB first at a 125 ns bit period; data is set while the clock is low.
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			serial_in_o <= tx[i];
			#62.5;
			sclk_o <= 1'b1;
			rx[i] = serial_out_i;
			#62.5;
			sclk_o <= 1'b0;
		end
	endtask
	// Header then bytes under one select; read values replace the queue.
	task automatic access(input logic [7:0] hdr, inout logic [7:0] q[$]);
		logic [7:0] rx;
		chip_select_n_o <= 1'b0;
		repeat (4) @(posedge clk_i);
		// A small offset keeps every serial clock and data edge of the bytes clear of the system clock's edges.
		#1.25;
		xfer(hdr, rx);
		foreach (q[k]) xfer(q[k], q[k]);
		repeat (8) @(posedge clk_i);
		chip_select_n_o <= 1'b1;
		serial_in_o <= ~serial_in_o;
		repeat (8) @(posedge clk_i);
	endtask
endmodule // spi_host_model

// ---- tb_radio_rx_host_port.sv ----
module tb_radio_rx_host_port;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i, rst_n_i, shutdown_in_i, rx_valid_i;
	logic [15:0] irq_event_i;
	logic [31:0] gpio_src_i;
	logic [7:0] rx_data_i;
	wire sclk_i, chip_select_n_i, serial_in_i, serial_out_o, serial_out_oe_n_o, irq_out_n_o;
	wire rx_ready_o, almost_full_o, side_band_o, high_band_o;
	wire [2:0] gpio_o;
	wire [4:0] band_field_o;
	wire [15:0] carrier_value_o;
	wire [7:0] hop_channel_o, hop_step_o;
	int error_cnt = 0;
	int num_checks = 0;
	logic [7:0] q[$];
	// ============================================================
	// Block and host.
	radio_rx_host_port u_radio_rx_host_port (.clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i),
		.chip_select_n_i(chip_select_n_i), .serial_in_i(serial_in_i), .serial_out_o(serial_out_o),
		.serial_out_oe_n_o(serial_out_oe_n_o), .shutdown_in_i(shutdown_in_i), .irq_out_n_o(irq_out_n_o),
		.irq_event_i(irq_event_i), .gpio_src_i(gpio_src_i), .gpio_o(gpio_o), .rx_data_i(rx_data_i),
		.rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o), .almost_full_o(almost_full_o),
		.side_band_o(side_band_o), .high_band_o(high_band_o), .band_field_o(band_field_o),
		.carrier_value_o(carrier_value_o), .hop_channel_o(hop_channel_o), .hop_step_o(hop_step_o));
	spi_host_model u_spi_host_model (.clk_i(clk_i), .serial_out_i(serial_out_o), .sclk_o(sclk_i),
		.chip_select_n_o(chip_select_n_i), .serial_in_o(serial_in_i));
	// Free-running system clock.
	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Frame of header and bytes; on reads the bytes are the expected values.
	task automatic xs(input logic [7:0] hdr, input logic [7:0] d[$]);
		q = d;
		u_spi_host_model.access(hdr, q);
		if (!hdr[7])
			foreach (d[k]) check(q[k], d[k]);
	endtask
	task automatic test_defaults;
		xs(8'h75, '{8'h75, 8'hbb, 8'h80});
		xs(8'h79, '{8'h00, 8'h00});
		xs(8'h7e, '{8'h37});
		check(carrier_value_o, 16'hbb80);
	endtask
	// Burst across the reserved hole, whose write must vanish.
	task automatic test_writes;
		xs(8'hf5, '{8'hff, 8'h12, 8'h34, 8'h99, 8'ha5, 8'h5a});
		xs(8'h75, '{8'h7f, 8'h12, 8'h34, 8'h00, 8'ha5, 8'h5a});
		check({side_band_o, high_band_o, band_field_o}, 7'h7f);
		check({carrier_value_o, hop_channel_o}, 24'h1234_a5);
		check(hop_step_o, 8'h5a);
	endtask
	task automatic test_queue_irq;
		xs(8'hfe, '{8'h02});
		xs(8'h85, '{8'h10});
		for (int i = 1; i < 4; i++)
		begin
			rx_data_i <= 8'(8'h11 * i);
			rx_valid_i <= 1'b1;
			@(posedge clk_i);
		end
		rx_valid_i <= 1'b0;
		irq_event_i <= 16'h0001;
		@(posedge clk_i);
		irq_event_i <= 16'h0000;
		repeat (4) @(posedge clk_i);
		check({almost_full_o, irq_out_n_o, rx_ready_o}, 3'b101);
		xs(8'h03, '{8'h10, 8'h01});
		check(irq_out_n_o, 1'b1);
		// The burst above cleared both status bytes, so a fresh event is raised.
		irq_event_i <= 16'h0001;
		@(posedge clk_i);
		irq_event_i <= 16'h0000;
		repeat (4) @(posedge clk_i);
		check(irq_out_n_o, 1'b1);
		xs(8'h86, '{8'h01});
		check(irq_out_n_o, 1'b0);
		xs(8'h04, '{8'h01});
		check(irq_out_n_o, 1'b1);
		xs(8'h7f, '{8'h11, 8'h22, 8'h33});
		xs(8'h7f, '{8'h00});
		check(almost_full_o, 1'b0);
	endtask
	task automatic test_gpio;
		xs(8'h8c, '{8'h05});
		gpio_src_i <= 32'h0000_0020;
		repeat (4) @(posedge clk_i);
		check(gpio_o, 3'b010);
		gpio_src_i <= 32'hffff_ffdf;
		repeat (4) @(posedge clk_i);
		check(gpio_o, 3'b101);
	endtask
	task automatic test_shutdown;
		shutdown_in_i <= 1'b1;
		repeat (12) @(posedge clk_i);
		check(serial_out_oe_n_o, 1'b1);
		shutdown_in_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		xs(8'h75, '{8'h75, 8'hbb, 8'h80, 8'h00, 8'h00, 8'h00});
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// A hung handshake must not stall the run.
	initial
	begin
		repeat (60000) @(posedge clk_i);
		error_cnt++;
		stop_test();
	end
	// Main sequence.
	initial
	begin
		{rst_n_i, shutdown_in_i, rx_valid_i, irq_event_i, gpio_src_i, rx_data_i} = '0;
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		test_defaults();
		test_writes();
		test_queue_irq();
		test_gpio();
		test_shutdown();
		stop_test();
	end
endmodule // tb_radio_rx_host_port
